// [exec_pkg.sv]
// constants shared by the execute slice: fields, opcodes, reset values
// assumes a 12-bit instruction word and an 8-bit data path in one clock domain
package exec_pkg;
    // widths of the data path
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int FADDR_W = 5;
    localparam int INSTR_W = 12;
    // instruction word fields
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 9;
    localparam int DEST_BIT = 5;
    localparam int FADDR_MSB = 4;
    localparam int LIT_MSB = 7;
    localparam int JUMP_MSB = 8;
    // status register layout
    localparam int NULL_BIT = 2;
    localparam int PAGE_MSB = 6;
    localparam int PAGE_LSB = 5;
    // file address at which the status register is mapped
    localparam logic [4:0] STATUS_ADDR = 5'h03;
    // reset values, and the step of one used by increment and decrement
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [7:0] ONE = 8'h01;
    // cycles taken by a taken skip and by a jump
    localparam int SKIP_CYCLES = 2;
    localparam int JUMP_CYCLES = 2;

    // operation classes, held in the top three bits of the word
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_DEC_SKIP = 3'h1,
        OP_INC_SKIP = 3'h2,
        OP_JUMP = 3'h3,
        OP_OR_LIT = 3'h4,
        OP_OR_FILE = 3'h5,
        OP_MOVE_TO_FILE = 3'h6,
        OP_RSVD = 3'h7
    } op_type;

    // an all-zero result, used for skips and for the null flag
    function automatic logic is_null(input logic [7:0] value);
        is_null = (value == 8'h00);
    endfunction : is_null
endpackage : exec_pkg

// [alu_if.sv]
// carrier between the execute control and its arithmetic unit
// assumes both ends sit in the core clock domain
`timescale 1ns/10ps
interface alu_if;
    exec_pkg::op_type op; // operation being executed
    logic [7:0] acc; // accumulator operand
    logic [7:0] file_data; // addressed file register operand
    logic [7:0] literal; // immediate operand
    logic [7:0] result; // computed value
    logic null_flag; // result is all zeros
    logic skip; // skip the prefetched word

    // the unit computes, the control consumes
    modport unit (input op, input acc, input file_data, input literal, output result, output null_flag, output skip);
    modport ctrl (output op, output acc, output file_data, output literal, input result, input null_flag, input skip);
endinterface : alu_if

// [exec_alu.sv]
// arithmetic unit of the execute slice: purely combinational
// assumes operands are stable for the whole cycle
`timescale 1ns/10ps
module exec_alu (
    // operands in, result out
    alu_if.unit bus
);
    // compute result and skip condition for the current operation
    always_comb
    begin
        bus.skip = 1'b0;
        unique case (bus.op)
            exec_pkg::OP_DEC_SKIP:
            begin
                bus.result = bus.file_data - exec_pkg::ONE;
                bus.skip = exec_pkg::is_null(bus.result);
            end
            exec_pkg::OP_INC_SKIP:
            begin
                bus.result = bus.file_data + exec_pkg::ONE;
                bus.skip = exec_pkg::is_null(bus.result);
            end
            exec_pkg::OP_OR_LIT: bus.result = bus.acc | bus.literal;
            exec_pkg::OP_OR_FILE: bus.result = bus.acc | bus.file_data;
            exec_pkg::OP_MOVE_TO_FILE: bus.result = bus.acc;
            // other classes need no result; pass the file value through
            default: bus.result = bus.file_data;
        endcase
        bus.null_flag = exec_pkg::is_null(bus.result);
    end
endmodule : exec_alu

// [exec_core.sv]
// execute slice of an 8-bit core: skips, jump, OR forms and accumulator store
// assumes program memory returns instr_i for pc_o within the same cycle
`timescale 1ns/10ps
// How it works
// - decrement file, result to accumulator or file
// - zero after decrement discards prefetched word
// - increment file, result to accumulator or file
// - zero after increment discards word, flags kept
// - jump loads nine bits plus page bits
// - jump takes two cycles, flags untouched
// - OR literal into accumulator, update null flag
// - OR accumulator with file, choose destination
// - store accumulator into file, flags untouched
module exec_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // instruction fetch
    input wire logic [11:0] instr_i,
    output logic [10:0] pc_o,
    // architectural state seen by the rest of the core
    output logic [7:0] acc_o,
    output logic [7:0] status_o,
    output logic flushed_o
);
    // architectural and pipeline state
    logic [7:0] acc_reg; // accumulator
    logic [7:0] acc_next;
    logic [7:0] status_reg; // status, mapped into the file space
    logic [7:0] status_next;
    logic [10:0] pc_reg; // fetch address
    logic [10:0] pc_next;
    logic [11:0] fetched_reg; // prefetched word awaiting execution
    logic [11:0] fetched_next;
    logic flush_reg; // the prefetched word is to be run as a no-operation
    logic flush_next;
    // file registers; the status slot is served by status_reg
    logic [7:0] file_mem [0:31];
    // decode and write controls
    exec_pkg::op_type cur_op; // operation executed this cycle
    logic [4:0] faddr; // addressed file register
    logic dest_file; // destination bit: 1 sends the result to the file
    logic [7:0] rd_data; // value read from the file space
    logic file_we; // file write this cycle
    logic [7:0] file_wdata; // data for that write
    logic upd_null; // this operation updates the null flag
    alu_if alu_bus ();

    // arithmetic unit
    exec_alu u_alu (
        .bus(alu_bus.unit)
    );

    // decode the prefetched word; a flushed word becomes a no-operation
    always_comb
    begin
        if (flush_reg)
        begin
            cur_op = exec_pkg::OP_NOP;
        end
        else
        begin
            cur_op = exec_pkg::op_type'(fetched_reg[exec_pkg::OPC_MSB:exec_pkg::OPC_LSB]);
        end
        faddr = fetched_reg[exec_pkg::FADDR_MSB:0];
        dest_file = fetched_reg[exec_pkg::DEST_BIT];
        // status lives at one file address so code can set the page bits
        if (faddr == exec_pkg::STATUS_ADDR)
        begin
            rd_data = status_reg;
        end
        else
        begin
            rd_data = file_mem[faddr];
        end
    end

    // operands to the arithmetic unit
    assign alu_bus.op = cur_op;
    assign alu_bus.acc = acc_reg;
    assign alu_bus.file_data = rd_data;
    assign alu_bus.literal = fetched_reg[exec_pkg::LIT_MSB:0];

    // next state of accumulator, status, fetch address and flush
    always_comb
    begin
        acc_next = acc_reg;
        status_next = status_reg;
        pc_next = pc_reg + 11'h001;
        fetched_next = instr_i;
        flush_next = 1'b0;
        file_we = 1'b0;
        file_wdata = alu_bus.result;
        upd_null = 1'b0;
        unique case (cur_op)
            // both skip forms: destination by the d bit, no flag change
            exec_pkg::OP_DEC_SKIP, exec_pkg::OP_INC_SKIP:
            begin
                if (dest_file)
                begin
                    file_we = 1'b1;
                end
                else
                begin
                    acc_next = alu_bus.result;
                end
                flush_next = alu_bus.skip;
            end
            // jump: the word already fetched is stale and is dropped
            exec_pkg::OP_JUMP:
            begin
                pc_next = {status_reg[exec_pkg::PAGE_MSB:exec_pkg::PAGE_LSB],
                           fetched_reg[exec_pkg::JUMP_MSB:0]};
                flush_next = 1'b1;
            end
            exec_pkg::OP_OR_LIT:
            begin
                acc_next = alu_bus.result;
                upd_null = 1'b1;
            end
            exec_pkg::OP_OR_FILE:
            begin
                if (dest_file)
                begin
                    file_we = 1'b1;
                end
                else
                begin
                    acc_next = alu_bus.result;
                end
                upd_null = 1'b1;
            end
            exec_pkg::OP_MOVE_TO_FILE:
            begin
                file_we = 1'b1;
            end
            // no-operation and the spare code change nothing
            default:
            begin
                upd_null = 1'b0;
            end
        endcase
        // a write to the status slot lands first; the flag update wins over it
        if (file_we && (faddr == exec_pkg::STATUS_ADDR))
        begin
            status_next = file_wdata;
        end
        if (upd_null)
        begin
            status_next[exec_pkg::NULL_BIT] = alu_bus.null_flag;
        end
    end

    // register the control state
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            acc_reg <= exec_pkg::ACC_RST;
            status_reg <= exec_pkg::STATUS_RST;
            pc_reg <= exec_pkg::PC_RST;
            fetched_reg <= 12'h000;
            // nothing valid was prefetched before reset, so run one empty cycle
            flush_reg <= 1'b1;
        end
        else
        begin
            acc_reg <= acc_next;
            status_reg <= status_next;
            pc_reg <= pc_next;
            fetched_reg <= fetched_next;
            flush_reg <= flush_next;
        end
    end

    // file array write; not reset, software initialises it
    always_ff @(posedge clk_i)
    begin
        if (file_we && (faddr != exec_pkg::STATUS_ADDR))
        begin
            file_mem[faddr] <= file_wdata;
        end
    end

    // outputs straight from flip-flops
    assign pc_o = pc_reg;
    assign acc_o = acc_reg;
    assign status_o = status_reg;
    assign flushed_o = flush_reg;

    a_dec_to_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_DEC_SKIP) && !dest_file |=> acc_reg == ($past(rd_data) - 8'h01))
        else $error("decrement result not in accumulator");
    a_dec_skip_two: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_DEC_SKIP) && (rd_data == 8'h01) |=> flush_reg ##1 !flush_reg)
        else $error("decrement to zero did not skip exactly one word");
    a_inc_skip_flags: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_INC_SKIP) && (rd_data == 8'hFF) && (faddr != exec_pkg::STATUS_ADDR)
        |=> flush_reg && $stable(status_reg))
        else $error("increment to zero did not skip or changed status");
    a_inc_to_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_INC_SKIP) && !dest_file && (rd_data != 8'hFF) |=> !flush_reg
        && acc_reg == ($past(rd_data) + 8'h01))
        else $error("increment result or skip wrong");
    a_jump_target: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_JUMP) |=> pc_reg == {$past(status_reg[6:5]), $past(fetched_reg[8:0])})
        else $error("jump target wrong");
    a_jump_two_cycles: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_JUMP) |=> flush_reg && $stable(status_reg) ##1 !flush_reg)
        else $error("jump not two cycles or touched status");
    a_or_literal: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_OR_LIT) |=> acc_reg == ($past(acc_reg) | $past(fetched_reg[7:0]))
        && status_reg[2] == (acc_reg == 8'h00))
        else $error("literal OR result or null flag wrong");
    a_or_file_null: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_OR_FILE) |=> status_reg[2] == (($past(acc_reg) | $past(rd_data)) == 8'h00))
        else $error("file OR null flag wrong");
    // looks at the array itself, so a lost or misaddressed write is caught, not just the write data
    a_move_store: assert property (@(posedge clk_i) disable iff (reset_i)
        (cur_op == exec_pkg::OP_MOVE_TO_FILE) && (faddr != exec_pkg::STATUS_ADDR)
        |=> (file_mem[$past(faddr)] == $past(acc_reg)) && $stable(status_reg))
        else $error("accumulator store wrong or touched status");
    a_null_exact: assert property (@(posedge clk_i) disable iff (reset_i)
        upd_null |=> status_reg[2] != $past(|alu_bus.result))
        else $error("null flag does not match result");
endmodule : exec_core

// [skip_branch_logic_move_ops_bench.sv]
// bench for exec_core: random program checked against a cycle model
// assumes the bench memory answers pc_o within the same cycle
`timescale 1ns/10ps
module skip_branch_logic_move_ops_bench;
    // design ports
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] instr_i = 12'h000;
    logic [10:0] pc_o;
    logic [7:0] acc_o;
    logic [7:0] status_o;
    logic flushed_o;
    // program memory and reference state
    logic [11:0] prog [0:2047];
    logic [7:0] model_file [0:31];
    logic [7:0] model_acc;
    logic [7:0] model_status;
    logic [10:0] model_pc;
    logic [11:0] model_fetch;
    logic model_flush;
    int err_total = 0;
    int check_count = 0;
    int flush_count = 0;
    logic [31:0] seed = 32'hCC5B5163;

    exec_core dut (.clk_i(clk_i), .reset_i(reset_i), .instr_i(instr_i), .pc_o(pc_o), .acc_o(acc_o),
        .status_o(status_o), .flushed_o(flushed_o));

    // 20 MHz core clock
    always #25 clk_i = ~clk_i;

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xorshift = y ^ (y << 5);
    endfunction : xorshift

    // the status byte is visible as a file register
    function automatic logic [7:0] file_rd(input logic [4:0] a);
        file_rd = (a == exec_pkg::STATUS_ADDR) ? model_status : model_file[a];
    endfunction : file_rd

    task automatic file_wr(input logic [4:0] a, input logic [7:0] v);
        if (a == exec_pkg::STATUS_ADDR)
            model_status = v;
        else
            model_file[a] = v;
    endtask : file_wr

    // one rising edge: run the held word unless flushed, then fetch
    task automatic model_step();
        logic [4:0] fa;
        logic [7:0] r;
        logic skip;
        logic [10:0] npc;
        fa = model_fetch[4:0];
        skip = 1'b0;
        npc = model_pc + 11'h001;
        if (!model_flush)
        begin
            case (model_fetch[11:9])
                exec_pkg::OP_DEC_SKIP, exec_pkg::OP_INC_SKIP:
                begin
                    // flags are left alone on both skip forms
                    r = (model_fetch[11:9] == exec_pkg::OP_DEC_SKIP) ? file_rd(fa) - 8'h01 : file_rd(fa) + 8'h01;
                    if (model_fetch[5])
                        file_wr(fa, r);
                    else
                        model_acc = r;
                    skip = (r == 8'h00);
                end
                exec_pkg::OP_JUMP:
                begin
                    npc = {model_status[6:5], model_fetch[8:0]};
                    skip = 1'b1;
                end
                exec_pkg::OP_OR_LIT:
                begin
                    model_acc = model_acc | model_fetch[7:0];
                    model_status[2] = (model_acc == 8'h00);
                end
                exec_pkg::OP_OR_FILE:
                begin
                    r = model_acc | file_rd(fa);
                    if (model_fetch[5])
                        file_wr(fa, r);
                    else
                        model_acc = r;
                    model_status[2] = (r == 8'h00);
                end
                exec_pkg::OP_MOVE_TO_FILE:
                    file_wr(fa, model_acc);
                default:
                    skip = 1'b0;
            endcase
        end
        flush_count += skip;
        model_fetch = prog[model_pc];
        model_pc = npc;
        model_flush = skip;
    endtask : model_step

    task automatic check_pc(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp)
            $display("FAIL %0t pc got %h expected %h", $time, got, exp);
        err_total += (got !== exp);
    endtask : check_pc

    task automatic check_data(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        err_total += (got !== exp);
    endtask : check_data

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
            $display("FAIL %0t flush got %b expected %b", $time, got, exp);
        err_total += (got !== exp);
    endtask : check_flag

    // falling edge: follow the last rising edge, compare, drive next word
    always @(negedge clk_i)
    begin
        if (reset_i)
        begin
            model_pc = exec_pkg::PC_RST;
            model_acc = exec_pkg::ACC_RST;
            model_status = exec_pkg::STATUS_RST;
            model_flush = 1'b1;
        end
        else
        begin
            model_step();
            check_pc(pc_o, model_pc);
            check_data(acc_o, model_acc, "acc");
            check_data(status_o, model_status, "status");
            check_flag(flushed_o, model_flush);
        end
        instr_i <= prog[model_pc];
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d flushes %0d", check_count, err_total, flush_count);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // main sequence: random memory, directed prefix, then free run
    initial
    begin
        for (int i = 0; i < 2048; i++)
        begin
            seed = xorshift(seed);
            prog[i] = seed[11:0];
            // keep random words off the status byte so page bits stay known
            if (prog[i][4:0] == 5'h03)
                prog[i][2] = 1'b1;
        end
        // clear every file register except the status slot with the zero accumulator
        for (int i = 0; i < 32; i++)
            prog[i] = {3'h6, 4'h0, (i == 3) ? 5'h04 : 5'(i)};
        prog[32] = 12'h840;
        prog[33] = 12'hC03;
        prog[34] = 12'h6A5;
        // page 2 target: wrap to zero, skips on both forms, boundary jump
        prog[11'h4A5] = 12'h220;
        prog[11'h4A6] = 12'h420;
        prog[11'h4A7] = 12'h8FF;
        prog[11'h4A8] = 12'h200;
        prog[11'h4A9] = 12'hA21;
        prog[11'h4AA] = 12'h401;
        prog[11'h4AB] = 12'h8FF;
        // file 0 goes 0 to 1, then the decrement to zero must drop the next word
        prog[11'h4AC] = 12'h420;
        prog[11'h4AD] = 12'h220;
        prog[11'h4AE] = 12'h8FF;
        prog[11'h4AF] = 12'h7FF;
        prog[11'h5FF] = 12'h800;
        repeat (20) @(negedge clk_i);
        reset_i <= 1'b0;
        repeat (1500) @(negedge clk_i);
        // second reset in mid-run: files keep their values, pc, acc and status restart
        reset_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        reset_i <= 1'b0;
        repeat (1500) @(negedge clk_i);
        complete_run();
    end

    // watchdog well beyond the planned run
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
endmodule : skip_branch_logic_move_ops_bench
